// ### rtl/ect_params.svh
// constants of the event counter, timers and output selectors
`ifndef ECT_PARAMS_SVH
`define ECT_PARAMS_SVH

`define ECT_CLK_HZ          20000000
`define ECT_CLK_NS          50
// register byte offsets
`define ECT_OFS_CTRL        8'h00
`define ECT_OFS_COUNT       8'h04
`define ECT_OFS_TIMER       8'h08
`define ECT_OFS_SKIP_A      8'h0C
`define ECT_OFS_SKIP_B      8'h10
`define ECT_OFS_REACH       8'h14
`define ECT_OFS_FREQ        8'h18
`define ECT_OFS_PID         8'h1C
`define ECT_OFS_STATUS      8'h20
`define ECT_OFS_RESTART     8'h24
// control register fields
`define ECT_CTRL_FIRST_LSB  0
`define ECT_CTRL_SECOND_LSB 8
`define ECT_CTRL_MON_LSB    16
`define ECT_CTRL_GAIN_LSB   20
`define ECT_CTRL_UPDOWN_BIT 28
`define ECT_CTRL_RETAIN_BIT 29
`define ECT_HI_LSB          16
// reset values
`define ECT_RST_CTRL        32'h0640_0201
`define ECT_RST_SKIP_B      32'h0032_0000
`define ECT_RST_ZERO        32'h0000_0000
// output selector codes
`define ECT_CODE_CNT_REACH  6'h10
`define ECT_CODE_STEP_END   6'h0E
`define ECT_CODE_PROC_END   6'h0F
`define ECT_CODE_MID_REACH  6'h11
// timing
`define ECT_TRIG_MIN_NS     2000000
`define ECT_TRIG_MIN_CYC    ((`ECT_TRIG_MIN_NS + `ECT_CLK_NS - 1) / `ECT_CLK_NS)
`define ECT_TICK1_NS        100000000
`define ECT_TICK1_CYC       (`ECT_TICK1_NS / `ECT_CLK_NS)
`define ECT_TICK2_NS        1000000000
`define ECT_TICK2_CYC       (`ECT_TICK2_NS / `ECT_CLK_NS)
`define ECT_PULSE_NS        100000000
`define ECT_PULSE_CYC       (`ECT_PULSE_NS / `ECT_CLK_NS)
`define ECT_NCO_WRAP        (100 * `ECT_CLK_HZ)
`define ECT_GAIN_FULL       100

`endif

// ### rtl/ect_pkg.sv
// types shared by the counter, timer and selector modules
package ect_pkg;
  typedef enum logic [1:0] {
    ECT_CNT_LOAD  = 2'b00,
    ECT_CNT_COUNT = 2'b01,
    ECT_CNT_DONE  = 2'b10
  } ect_cnt_state_t;

  typedef struct packed {
    logic           p1, p2, c1, c2;
    logic           filt_lvl;
    logic [15:0]    filt_cnt;
    ect_cnt_state_t st;
    logic [13:0]    remaining;
    logic           mid_q;
    logic           pf_q;
  } ect_cnt_t;

  typedef struct packed {
    logic        s1, s2;
    logic [24:0] tick;
    logic [7:0]  elapsed;
  } ect_tmr_t;
endpackage

// ### rtl/ect_counter.sv
// down counting event counter with trigger filter and reset terminal
`timescale 1ns/1ns
`include "ect_params.svh"
module ect_counter
  import ect_pkg::*;
#(
  parameter int TRIG_MIN_CYC = `ECT_TRIG_MIN_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // terminals and drive status
  input  wire logic        pulse_pin,
  input  wire logic        clear_pin,
  input  wire logic        power_fail,
  // settings
  input  wire logic        retain,
  input  wire logic [13:0] set_value,
  input  wire logic [13:0] mid_value,
  // results
  output logic      [13:0] remaining,
  output logic             done,
  output logic             mid_pulse
);
  ect_cnt_t q, d;
  logic       trig;
  logic [13:0] counted;
  logic       mid_lvl;

  assign counted   = set_value - q.remaining;
  // intermediate compare only meaningful below the set value
  assign mid_lvl   = (mid_value < set_value) && (q.st != ECT_CNT_LOAD)
                     && (counted >= mid_value);
  assign trig      = (q.filt_cnt == 16'(TRIG_MIN_CYC - 1)) && q.p2 && !q.filt_lvl;
  assign remaining = q.remaining;
  assign done      = (q.st == ECT_CNT_DONE);
  assign mid_pulse = mid_lvl && !q.mid_q;

  // filter accepts a level only after it held for the least width
  always_comb begin
    d    = q;
    d.p1 = pulse_pin;
    d.p2 = q.p1;
    d.c1 = clear_pin;
    d.c2 = q.c1;
    d.pf_q  = power_fail;
    d.mid_q = mid_lvl;
    if (q.p2 == q.filt_lvl) begin
      d.filt_cnt = '0;
    end else if (q.filt_cnt == 16'(TRIG_MIN_CYC - 1)) begin
      d.filt_lvl = q.p2;
      d.filt_cnt = '0;
    end else begin
      d.filt_cnt = q.filt_cnt + 16'h0001;
    end
    unique case (q.st)
      ECT_CNT_LOAD: begin
        d.remaining = set_value;
        d.st = (set_value == 14'h0000) ? ECT_CNT_DONE : ECT_CNT_COUNT;
      end
      ECT_CNT_COUNT: begin
        if (trig) begin
          d.remaining = q.remaining - 14'h0001;
          if (q.remaining == 14'h0001) begin
            d.st = ECT_CNT_DONE;
          end
        end
      end
      ECT_CNT_DONE: begin
        d.remaining = 14'h0000;
      end
      default: begin
        d.st = ECT_CNT_LOAD;
      end
    endcase
    // reset terminal reloads; power loss reloads unless retained
    if (q.c2 || (power_fail && !q.pf_q && !retain)) begin
      d.st = ECT_CNT_LOAD;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '{st: ECT_CNT_LOAD, default: '0};
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  done_zero_a: assert property (done |-> remaining == 14'h0000)
    else $error("done counter shows nonzero");
  done_hold_a: assert property (done && !q.c2 && !power_fail |=> done)
    else $error("done counter left done without reset");
  clear_load_a: assert property (q.c2 |=> ##1 remaining == $past(set_value))
    else $error("reset terminal did not reload");
  mid_one_a: assert property (mid_pulse |=> !mid_pulse)
    else $error("intermediate pulse longer than one cycle");
  mid_below_a: assert property (mid_pulse |-> mid_value < set_value)
    else $error("intermediate pulse with value not below set");
  cnt_step_c: cover property (trig && q.st == ECT_CNT_COUNT);
  cnt_done_c: cover property (!done ##1 done);
endmodule

// ### rtl/ect_timer.sv
// externally started timer with tick prescaler
`timescale 1ns/1ns
`include "ect_params.svh"
module ect_timer
  import ect_pkg::*;
#(
  parameter int TICK_CYC = `ECT_TICK1_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // start terminal and drive status
  input  wire logic       start_pin,
  input  wire logic       power_fail,
  // period in ticks
  input  wire logic [6:0] period,
  // result
  output logic            reached
);
  ect_tmr_t q, d;

  assign reached = q.s2 && (q.elapsed >= {1'b0, period});

  // a fault stop does not touch the timer; power loss or an open start input clears it
  always_comb begin
    d    = q;
    d.s1 = start_pin;
    d.s2 = q.s1;
    if (!q.s2 || power_fail) begin
      d.tick    = '0;
      d.elapsed = '0;
    end else if (q.tick == 25'(TICK_CYC - 1)) begin
      d.tick = '0;
      if (q.elapsed != 8'hFF) begin
        d.elapsed = q.elapsed + 8'h01;
      end
    end else begin
      d.tick = q.tick + 25'h0000001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  pf_clear_a: assert property (power_fail |=> q.elapsed == 8'h00)
    else $error("timer kept time across power loss");
  open_clear_a: assert property (!q.s2 |-> !reached)
    else $error("timer output with input open");
  tmr_reach_c: cover property (!reached ##1 reached);
endmodule

// ### rtl/ect_top.sv
// event counter, timers, output selectors, monitor and register bank
// Behaviour
// - counter reloads set value, counts down
// - reaching target shows 0, ignores pulses
// - retention option keeps count over power loss
// - set value 0..9999, reset restarts counting
// - code 16 asserts when count reaches set
// - code 17 pulses once at intermediate value
// - intermediate valid only below set value
// - codes 00 none, 01 run, 02 fault
// - codes 03 04 08 09 speed and braking
// - codes 05 06 07 frequency reach
// - codes 10..13 overload, torque, undervoltage
// - codes 14 15 pulse at step, process end
// - code 27 set on drawing, cleared on stop
// - codes 28 29 PID low and high alarms
// - code 30 fan, 32 brake, 21..26 reserved
// - monitor codes 0..3 scaled analog level
// - monitor codes 4..7 pulses 1,2,3,6 per Hz
// - up/down memory chooses restart frequency
// - timers run while closed, output at period
// - fault stop keeps timers, power loss resets
// - three skip bands, zero width disables
// - reset terminal reloads the counter
// - timer start terminals start their timers
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`include "ect_params.svh"
module ect_top
  import ect_pkg::*;
#(
  parameter int TRIG_MIN_CYC = `ECT_TRIG_MIN_CYC,
  parameter int TICK1_CYC    = `ECT_TICK1_CYC,
  parameter int TICK2_CYC    = `ECT_TICK2_CYC,
  parameter int PULSE_CYC    = `ECT_PULSE_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // terminals
  input  wire logic        counter_pulse_pin,
  input  wire logic        counter_reset_pin,
  input  wire logic        timer_one_start_pin,
  input  wire logic        timer_two_start_pin,
  // drive status, same clock domain
  input  wire logic        running,
  input  wire logic        run_command,
  input  wire logic        fault,
  input  wire logic        dc_braking,
  input  wire logic        accelerating,
  input  wire logic        decelerating,
  input  wire logic        drive_overload,
  input  wire logic        motor_overload,
  input  wire logic        overtorque,
  input  wire logic        undervoltage,
  input  wire logic        step_end_pulse,
  input  wire logic        process_end_pulse,
  input  wire logic        analog_loss,
  input  wire logic        drawing_done,
  input  wire logic        high_temperature,
  input  wire logic        relay_pulled,
  input  wire logic        brake_voltage,
  input  wire logic        drive_stop,
  input  wire logic        power_fail,
  // frequencies in 0.01 Hz, feedback in its own units
  input  wire logic [15:0] output_freq,
  input  wire logic [15:0] set_freq,
  input  wire logic [15:0] start_freq,
  input  wire logic [15:0] request_freq,
  input  wire logic [15:0] pid_feedback,
  // monitor sources, full scale 1023 is 10 V
  input  wire logic [9:0]  mon_freq_frac,
  input  wire logic [9:0]  mon_current_frac,
  input  wire logic [9:0]  mon_dc_frac,
  input  wire logic [9:0]  mon_ac_frac,
  // outputs
  output logic             transistor_output_select,
  output logic             relay_output_select,
  output logic             monitor_output,
  output logic [9:0]       monitor_level,
  output logic             skip_active,
  output logic [15:0]      restart_freq
);
  typedef struct packed {
    logic [31:0]      ctrl, count, timer, skip_a, skip_b, reach, freq, pid;
    logic [15:0]      held;
    logic             held_valid;
    logic             draw;
    logic [1:0][24:0] stretch;
    logic [1:0]       outs;
    logic [31:0]      acc;
    logic             mon_pulse;
    logic [9:0]       mon_level;
    logic [31:0]      rdata;
  } ect_top_t;

  ect_top_t q, d;

  logic [5:0]  out_code [2];
  logic [2:0]  mon_code;
  logic [6:0]  gain;
  logic [63:0] cond;
  logic [13:0] remaining;
  logic        cnt_done, mid_pulse, t1_reached, t2_reached;
  logic        acc_write, known;
  logic [31:0] inc;
  logic [16:0] scaled;
  logic [9:0]  mon_src;

  assign out_code[0] = q.ctrl[`ECT_CTRL_FIRST_LSB +: 6];
  assign out_code[1] = q.ctrl[`ECT_CTRL_SECOND_LSB +: 6];
  assign mon_code    = q.ctrl[`ECT_CTRL_MON_LSB +: 3];
  assign gain        = q.ctrl[`ECT_CTRL_GAIN_LSB +: 7];

  // pulse-type selector codes are stretched so a relay can see them
  function automatic logic is_pulse_code(input logic [5:0] c);
    return (c == `ECT_CODE_STEP_END) || (c == `ECT_CODE_PROC_END) ||
           (c == `ECT_CODE_MID_REACH);
  endfunction

  // band test for one skip point, band is twice the width
  function automatic logic in_band(input logic [15:0] f, p, w);
    logic [16:0] lo, hi;
    lo = {1'b0, p} - {1'b0, w};
    hi = {1'b0, p} + {1'b0, w};
    return ({1'b0, f} > lo) && ({1'b0, f} < hi) && (p >= w);
  endfunction

  // pulses per hertz for the pulse train codes
  function automatic logic [2:0] pulse_mult(input logic [2:0] c);
    unique case (c[1:0])
      2'b00:   return 3'd1;
      2'b01:   return 3'd2;
      2'b10:   return 3'd3;
      2'b11:   return 3'd6;
    endcase
  endfunction

  ect_counter #(
    .TRIG_MIN_CYC (TRIG_MIN_CYC)
  ) u_counter (
    .clk        (clk),
    .rst        (rst),
    .pulse_pin  (counter_pulse_pin),
    .clear_pin  (counter_reset_pin),
    .power_fail (power_fail),
    .retain     (q.ctrl[`ECT_CTRL_RETAIN_BIT]),
    .set_value  (q.count[13:0]),
    .mid_value  (q.count[`ECT_HI_LSB +: 14]),
    .remaining  (remaining),
    .done       (cnt_done),
    .mid_pulse  (mid_pulse)
  );

  ect_timer #(
    .TICK_CYC   (TICK1_CYC)
  ) u_timer_one (
    .clk        (clk),
    .rst        (rst),
    .start_pin  (timer_one_start_pin),
    .power_fail (power_fail),
    .period     (q.timer[6:0]),
    .reached    (t1_reached)
  );

  ect_timer #(
    .TICK_CYC   (TICK2_CYC)
  ) u_timer_two (
    .clk        (clk),
    .rst        (rst),
    .start_pin  (timer_two_start_pin),
    .power_fail (power_fail),
    .period     (q.timer[14:8]),
    .reached    (t2_reached)
  );

  // condition vector indexed by selector code; unlisted codes stay low
  always_comb begin
    cond     = '0;
    cond[1]  = running || run_command;
    cond[2]  = fault;
    cond[3]  = output_freq < start_freq;
    cond[4]  = dc_braking;
    cond[5]  = running && (output_freq == set_freq);
    cond[6]  = running && (output_freq >= q.reach[15:0]);
    cond[7]  = running && (output_freq >= q.reach[`ECT_HI_LSB +: 16]);
    cond[8]  = accelerating;
    cond[9]  = decelerating;
    cond[10] = drive_overload;
    cond[11] = motor_overload;
    cond[12] = overtorque;
    cond[13] = undervoltage;
    cond[14] = step_end_pulse;
    cond[15] = process_end_pulse;
    cond[16] = cnt_done;
    cond[17] = mid_pulse;
    cond[18] = t1_reached;
    cond[19] = t2_reached;
    cond[20] = analog_loss;
    cond[27] = q.draw;
    cond[28] = pid_feedback < q.pid[`ECT_HI_LSB +: 16];
    cond[29] = pid_feedback > q.pid[15:0];
    cond[30] = running || high_temperature;
    cond[31] = relay_pulled;
    cond[32] = running && brake_voltage;
  end

  // monitor source select and gain scaling
  always_comb begin
    unique case (mon_code[1:0])
      2'b00:   mon_src = mon_freq_frac;
      2'b01:   mon_src = mon_current_frac;
      2'b10:   mon_src = mon_dc_frac;
      2'b11:   mon_src = mon_ac_frac;
    endcase
    scaled = 17'((mon_src * gain) / `ECT_GAIN_FULL);
    inc    = 32'(output_freq * pulse_mult(mon_code) * 2);
  end

  assign known = (paddr[7:2] <= `ECT_OFS_RESTART >> 2) && (paddr[1:0] == 2'b00);
  assign acc_write = psel && penable && pwrite && known;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !known;
  assign prdata    = q.rdata;
  assign transistor_output_select = q.outs[0];
  assign relay_output_select      = q.outs[1];
  assign monitor_output           = q.mon_pulse;
  assign monitor_level            = q.mon_level;
  assign restart_freq = (q.ctrl[`ECT_CTRL_UPDOWN_BIT] && q.held_valid) ? q.held
                        : q.freq[15:0];
  // zero width turns every skip point off
  assign skip_active  = (q.skip_b[`ECT_HI_LSB +: 16] != 16'h0000) && (
                        in_band(request_freq, q.skip_a[15:0], q.skip_b[`ECT_HI_LSB +: 16]) ||
                        in_band(request_freq, q.skip_a[`ECT_HI_LSB +: 16],
                                q.skip_b[`ECT_HI_LSB +: 16]) ||
                        in_band(request_freq, q.skip_b[15:0], q.skip_b[`ECT_HI_LSB +: 16]));

  // next state: registers, read data, selectors, monitor, memory
  always_comb begin
    d = q;
    if (acc_write) begin
      unique case (paddr)
        `ECT_OFS_CTRL:   d.ctrl   = pwdata;
        `ECT_OFS_COUNT:  d.count  = pwdata;
        `ECT_OFS_TIMER:  d.timer  = pwdata;
        `ECT_OFS_SKIP_A: d.skip_a = pwdata;
        `ECT_OFS_SKIP_B: d.skip_b = pwdata;
        `ECT_OFS_REACH:  d.reach  = pwdata;
        `ECT_OFS_FREQ:   d.freq   = pwdata;
        `ECT_OFS_PID:    d.pid    = pwdata;
        default:         d.ctrl   = q.ctrl;
      endcase
    end
    // read data captured in the setup phase, so pready can stay high
    if (psel && !penable) begin
      unique case (paddr)
        `ECT_OFS_CTRL:    d.rdata = q.ctrl;
        `ECT_OFS_COUNT:   d.rdata = q.count;
        `ECT_OFS_TIMER:   d.rdata = q.timer;
        `ECT_OFS_SKIP_A:  d.rdata = q.skip_a;
        `ECT_OFS_SKIP_B:  d.rdata = q.skip_b;
        `ECT_OFS_REACH:   d.rdata = q.reach;
        `ECT_OFS_FREQ:    d.rdata = q.freq;
        `ECT_OFS_PID:     d.rdata = q.pid;
        `ECT_OFS_STATUS:  d.rdata = {14'h0000, skip_active, t2_reached, t1_reached,
                                     cnt_done, remaining};
        `ECT_OFS_RESTART: d.rdata = {16'h0000, restart_freq};
        default:          d.rdata = 32'h0000_0000;
      endcase
    end
    // drawing reach latches, set wins over the stop clear
    if (drawing_done) begin
      d.draw = 1'b1;
    end else if (!running) begin
      d.draw = 1'b0;
    end
    // each output decodes its own code
    for (int i = 0; i < 2; i++) begin
      if (!is_pulse_code(out_code[i])) begin
        d.stretch[i] = '0;
        d.outs[i]    = cond[out_code[i]];
      end else if (cond[out_code[i]]) begin
        d.stretch[i] = 25'(PULSE_CYC - 1);
        d.outs[i]    = 1'b1;
      end else if (q.stretch[i] != '0) begin
        d.stretch[i] = q.stretch[i] - 25'h0000001;
        d.outs[i]    = 1'b1;
      end else begin
        d.outs[i]    = 1'b0;
      end
    end
    // pulse train toggles at twice the rate, giving a square wave
    if (mon_code[2]) begin
      if (q.acc + inc >= 32'(`ECT_NCO_WRAP)) begin
        d.acc       = q.acc + inc - 32'(`ECT_NCO_WRAP);
        d.mon_pulse = !q.mon_pulse;
      end else begin
        d.acc = q.acc + inc;
      end
      d.mon_level = 10'h000;
    end else begin
      d.acc       = 32'h0000_0000;
      d.mon_pulse = 1'b0;
      d.mon_level = (scaled > 17'h003FF) ? 10'h3FF : scaled[9:0];
    end
    // up/down memory: power loss forgets the held frequency
    if (power_fail) begin
      d.held_valid = 1'b0;
    end else if (drive_stop) begin
      d.held       = output_freq;
      d.held_valid = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q        <= '0;
      q.ctrl   <= `ECT_RST_CTRL;
      q.skip_b <= `ECT_RST_SKIP_B;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  code16_out_a: assert property (out_code[1] == `ECT_CODE_CNT_REACH && $stable(out_code[1])
                                 |=> relay_output_select == $past(cnt_done))
    else $error("code 16 output differs from counter reach");
  draw_clear_a: assert property (!running && !drawing_done |=> !q.draw)
    else $error("drawing reach not cleared at stop");
  skip_off_a: assert property (q.skip_b[`ECT_HI_LSB +: 16] == 16'h0000 |-> !skip_active)
    else $error("skip active with zero width");
  pf_restart_a: assert property (power_fail |=> restart_freq == q.freq[15:0])
    else $error("restart after power loss not main setting");
  pulse_len_a: assert property ($rose(q.outs[0]) && is_pulse_code(out_code[0])
                                && $stable(out_code[0]) && !cond[out_code[0]]
                                |=> q.outs[0])
    else $error("pulse code output shorter than stretch");
  unmapped_a: assert property (psel && penable && paddr == 8'hFC |-> pslverr)
    else $error("unmapped address not refused");
  write_c: cover property (acc_write && paddr == `ECT_OFS_CTRL);
  mon_pulse_c: cover property (mon_code[2] && $changed(q.mon_pulse));
endmodule

// ### testbench/ect_switch_model.sv
// proximity switch model driving the counter trigger terminal
`timescale 1ns/1ns
module ect_switch_model #(
  parameter int HOLD = 10
) (
  // clock and request
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [3:0] pulses,
  // terminal side
  output logic            pin,
  output logic            busy
);
  logic [4:0] left;
  logic [7:0] t;
  initial begin
    pin = 1'b0;
    left = 5'h00;
    t = 8'h00;
  end
  assign busy = (left != 5'h00);
  // both phases held HOLD cycles, above the filter length and the rate limit
  always @(posedge clk) begin
    if (go) begin
      left <= {pulses, 1'b0};
      t    <= 8'h00;
    end else if (busy && t == 8'(HOLD - 1)) begin
      t    <= 8'h00;
      pin  <= ~pin;
      left <= left - 5'h01;
    end else if (busy) begin
      t <= t + 8'h01;
    end
  end
endmodule

// ### testbench/event_counter_timer_output_select_bench.sv
// bench for counter, timers, selectors, skip bands and restart frequency
`timescale 1ns/1ns
`include "ect_params.svh"
module event_counter_timer_output_select_bench;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, crst, t1, t2, go, pin, busy;
  logic        tos, ros, mo, sk;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, er;
  logic [18:0] lv;
  logic [15:0] of, rq, rf;
  logic [9:0]  mf, ml;
  logic [3:0]  np;
  int          fails, comparisons;
  logic [5:0]  code [10] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h1E};
  int          bitn [10] = '{0, 2, 3, 4, 5, 6, 7, 8, 9, 14};
  ect_top #(.TRIG_MIN_CYC(4), .TICK1_CYC(8), .TICK2_CYC(16), .PULSE_CYC(4)) dut_u (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .counter_pulse_pin(pin), .counter_reset_pin(crst), .timer_one_start_pin(t1),
    .timer_two_start_pin(t2), .running(lv[0]), .run_command(lv[1]), .fault(lv[2]),
    .dc_braking(lv[3]), .accelerating(lv[4]), .decelerating(lv[5]), .drive_overload(lv[6]),
    .motor_overload(lv[7]), .overtorque(lv[8]), .undervoltage(lv[9]),
    .step_end_pulse(lv[10]), .process_end_pulse(lv[11]), .analog_loss(lv[12]),
    .drawing_done(lv[13]), .high_temperature(lv[14]), .relay_pulled(lv[15]),
    .brake_voltage(lv[16]), .drive_stop(lv[17]), .power_fail(lv[18]), .output_freq(of),
    .set_freq(of), .start_freq(of), .request_freq(rq), .pid_feedback(of),
    .mon_freq_frac(mf), .mon_current_frac(mf), .mon_dc_frac(mf), .mon_ac_frac(mf),
    .transistor_output_select(tos), .relay_output_select(ros), .monitor_output(mo),
    .monitor_level(ml), .skip_active(sk), .restart_freq(rf));
  ect_switch_model #(.HOLD(10)) sw_u (.clk(clk), .go(go), .pulses(np), .pin(pin), .busy(busy));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic finish_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits for pready, releases only after it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = 32'(pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fails++;
      finish_test();
    end
  endtask
  task automatic rdk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd & m, e);
  endtask
  // n trigger pulses from the switch, then time for filter and sync
  task automatic sw(input logic [3:0] n);
    int i;
    @(posedge clk);
    go <= 1'b1;
    np <= n;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
    if (i >= 400) begin
      fails++;
      finish_test();
    end
    repeat (12) @(posedge clk);
  endtask
  task automatic clr();
    crst <= 1'b1;
    repeat (3) @(posedge clk);
    crst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    {rst, psel, penable, pwrite, crst, t1, t2, go} = 8'h80;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    lv = '0;
    of = 16'h0000;
    rq = 16'h0000;
    mf = 10'h000;
    np = 4'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdk(`ECT_OFS_CTRL, 32'hFFFF_FFFF, `ECT_RST_CTRL);
    rdk(`ECT_OFS_SKIP_B, 32'hFFFF_FFFF, `ECT_RST_SKIP_B);
    apb(1'b0, 8'hFC, 32'h0000_0000);
    chk(rd | er, 32'h0000_0001);
    apb(1'b1, `ECT_OFS_COUNT, 32'h0000_0003);
    clr();
    rdk(`ECT_OFS_STATUS, 32'h0000_7FFF, 32'h0000_0003);
    sw(4'h1);
    rdk(`ECT_OFS_STATUS, 32'h0000_7FFF, 32'h0000_0002);
    sw(4'h2);
    rdk(`ECT_OFS_STATUS, 32'h0000_7FFF, 32'h0000_4000);
    apb(1'b1, `ECT_OFS_CTRL, 32'h0640_1010);
    repeat (3) @(posedge clk);
    chk(32'({tos, ros}), 32'h0000_0003);
    sw(4'h1);
    rdk(`ECT_OFS_STATUS, 32'h0000_7FFF, 32'h0000_4000);
    clr();
    rdk(`ECT_OFS_STATUS, 32'h0000_7FFF, 32'h0000_0003);
    // selector codes on the relay while the transistor output stays empty
    for (int k = 0; k < 10; k++) begin
      apb(1'b1, `ECT_OFS_CTRL, 32'h0640_0000 | (32'(code[k]) << 8));
      lv[bitn[k]] <= 1'b1;
      repeat (3) @(posedge clk);
      chk(32'({tos, ros}), 32'h0000_0001);
      lv <= '0;
      repeat (3) @(posedge clk);
      chk(32'(ros), 32'h0000_0000);
    end
    apb(1'b1, `ECT_OFS_TIMER, 32'h0000_0102);
    {t1, t2} <= 2'b11;
    repeat (5) @(posedge clk);
    rdk(`ECT_OFS_STATUS, 32'h0001_8000, 32'h0000_0000);
    repeat (30) @(posedge clk);
    rdk(`ECT_OFS_STATUS, 32'h0001_8000, 32'h0001_8000);
    // power loss clears running timers at once
    lv[18] <= 1'b1;
    rdk(`ECT_OFS_STATUS, 32'h0001_8000, 32'h0000_0000);
    lv[18] <= 1'b0;
    {t1, t2} <= 2'b00;
    repeat (3) @(posedge clk);
    rdk(`ECT_OFS_STATUS, 32'h0001_8000, 32'h0000_0000);
    apb(1'b1, `ECT_OFS_SKIP_A, 32'h0000_03E8);
    rq <= 16'd1020;
    repeat (2) @(posedge clk);
    chk(32'(sk), 32'h0000_0001);
    rq <= 16'd1060;
    repeat (2) @(posedge clk);
    chk(32'(sk), 32'h0000_0000);
    apb(1'b1, `ECT_OFS_SKIP_B, 32'h0000_0000);
    rq <= 16'd1020;
    repeat (2) @(posedge clk);
    chk(32'(sk), 32'h0000_0000);
    apb(1'b1, `ECT_OFS_FREQ, 32'h0000_04D2);
    repeat (2) @(posedge clk);
    chk(32'(rf), 32'h0000_04D2);
    // up/down memory: stop frequency kept, power loss returns to main setting
    apb(1'b1, `ECT_OFS_CTRL, 32'h1640_1E00);
    of <= 16'h0123;
    lv[17] <= 1'b1;
    @(posedge clk);
    lv[17] <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(rf), 32'h0000_0123);
    lv[18] <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'(rf), 32'h0000_04D2);
    lv <= '0;
    // analog monitor at full gain follows its source, pulse output idle
    mf <= 10'h155;
    repeat (2) @(posedge clk);
    chk(32'({mo, ml}), 32'h0000_0155);
    finish_test();
  end
endmodule
